// file: verilog/aps_ctl.sv
/*
  Power-state decode, integrity status, filter window and bias-trim
  settings of the angle sensor, reached through its serial port.
  Assumes serial pins and the enable/cycle pins are asynchronous to
  clock_i and are therefore synchronised here; the serial clock must be
  slower than a quarter of clock_i.
*/
`timescale 1ns/100ps
module aps_ctl
  import aps_pkg::*;
#(
  parameter int US_CYCLES   = CYCLES_PER_US,
  parameter int BUSY_CYCLES = NVM_BUSY_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  input  wire logic        cs_n_i,
  input  wire logic        parity_mode_i,
  input  wire logic        enable_pin_i,
  input  wire logic        auto_cycle_pin_i,
  output logic             miso_o,
  output logic             fault_o,
  output logic             memory_busy_pin_o,
  output logic             settled_flag_o,
  output logic [2:0]       power_state_o,
  output logic [12:0]      filter_tau_o,
  output logic [13:0]      latency_us_o,
  output logic [7:0]       trim_x_amount_o,
  output logic [7:0]       trim_y_amount_o,
  output logic             side_shaft_corr_o
);

  function automatic logic [12:0] tau_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > FILTER_CODE_MAX) ? FILTER_CODE_MAX : code;
    tau_of = 13'h0001 << c;
  endfunction : tau_of

  function automatic logic [7:0] sum_of(input logic [31:0] v);
    sum_of = v[7:0] + v[15:8] + v[23:16] + v[31:24];
  endfunction : sum_of

  // two-stage synchronisers for every pin
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic       sclk_last_reg;
  logic       cs_n_last_reg;
  always_ff @(posedge clock_i) begin
    pin_meta_reg  <= {sclk_i, mosi_i, cs_n_i, parity_mode_i,
                      enable_pin_i, auto_cycle_pin_i};
    pin_sync_reg  <= pin_meta_reg;
    sclk_last_reg <= pin_sync_reg[5];
    cs_n_last_reg <= pin_sync_reg[3];
  end
  wire logic sclk_s   = pin_sync_reg[5];
  wire logic mosi_s   = pin_sync_reg[4];
  wire logic cs_n_s   = pin_sync_reg[3];
  wire logic parity_s = pin_sync_reg[2];
  wire logic en_s     = pin_sync_reg[1];
  wire logic asc_s    = pin_sync_reg[0];
  wire logic sclk_rise = sclk_s & ~sclk_last_reg & ~cs_n_s;
  wire logic sclk_fall = ~sclk_s & sclk_last_reg & ~cs_n_s;
  wire logic frame_end = cs_n_s & ~cs_n_last_reg;

  // serial shift registers
  logic [16:0] rx_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] tx_reg;
  logic [15:0] reply_reg;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_reg      <= 17'h00000;
      bit_cnt_reg <= 5'h00;
    end else if (frame_end) begin
      bit_cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[15:0], mosi_s};
      if (bit_cnt_reg != 5'h1F)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_reg <= 16'h0000;
      miso_o <= 1'b0;
    end else if (cs_n_s) begin
      tx_reg <= reply_reg;
      miso_o <= reply_reg[15];
    end else if (sclk_fall && bit_cnt_reg != 5'h00) begin
      tx_reg <= {tx_reg[14:0], 1'b0};
      miso_o <= tx_reg[14];
    end
  end

  // frame decode; with parity the word sits in rx[16:1]
  wire logic        got16   = (bit_cnt_reg == 5'(FRAME_BITS));
  wire logic        got17   = (bit_cnt_reg == 5'(FRAME_PBITS));
  wire logic [15:0] word    = got17 ? rx_reg[16:1] : rx_reg[15:0];
  wire logic [2:0]  cmd     = word[15:13];
  wire logic [4:0]  addr    = word[12:8];
  wire logic [7:0]  wdata   = word[7:0];
  wire logic        frame_ok = frame_end & (got16 | got17);
  wire logic        is_write = frame_ok & (cmd == CMD_WRITE);
  wire logic        parity_bad = parity_s & (~got17 | (^rx_reg));
  wire logic        write_ok = is_write & ~parity_bad;
  wire logic        mem_cmd  = frame_ok &
                      (cmd == CMD_STORE || cmd == CMD_RESTORE);
  wire logic        mem_go   = mem_cmd & ~memory_busy_pin_o;

  // configuration registers
  logic [7:0]  trim_amount_reg;
  logic [7:0]  trim_axes_reg;
  logic [7:0]  power_cfg_reg;
  logic [7:0]  filter_reg;
  logic [31:0] nvm_mem_reg;
  logic [7:0]  nvm_sum_reg;
  wire logic   restore_go = mem_go & (cmd == CMD_RESTORE);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trim_amount_reg <= RST_TRIM_AMOUNT;
      trim_axes_reg   <= RST_TRIM_AXES;
      power_cfg_reg   <= RST_POWER_CFG;
      filter_reg      <= RST_FILTER;
    end else if (restore_go) begin
      {trim_amount_reg, trim_axes_reg, power_cfg_reg, filter_reg}
        <= nvm_mem_reg;
    end else if (write_ok) begin
      case (addr)
        ADDR_TRIM_AMOUNT: trim_amount_reg <= wdata;
        ADDR_TRIM_AXES:   trim_axes_reg   <= {6'h00, wdata[1:0]};
        ADDR_POWER_CFG:   power_cfg_reg   <= {wdata[7:5], 5'h00};
        ADDR_FILTER:      filter_reg      <= {wdata[7:4], 4'h0};
        default:          ;
      endcase
    end
  end

  // non-volatile copy with its checksum; busy window after each access
  logic [23:0] busy_cnt_reg;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      nvm_mem_reg <= {RST_TRIM_AMOUNT, RST_TRIM_AXES,
                      RST_POWER_CFG, RST_FILTER};
      nvm_sum_reg <= sum_of({RST_TRIM_AMOUNT, RST_TRIM_AXES,
                             RST_POWER_CFG, RST_FILTER});
    end else if (mem_go && cmd == CMD_STORE) begin
      nvm_mem_reg <= {trim_amount_reg, trim_axes_reg,
                      power_cfg_reg, filter_reg};
      nvm_sum_reg <= sum_of({trim_amount_reg, trim_axes_reg,
                             power_cfg_reg, filter_reg});
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_cnt_reg      <= 24'h000000;
      memory_busy_pin_o <= 1'b0;
    end else if (mem_go) begin
      busy_cnt_reg      <= 24'(BUSY_CYCLES - 1);
      memory_busy_pin_o <= 1'b1;
    end else if (busy_cnt_reg != 24'h000000) begin
      busy_cnt_reg <= busy_cnt_reg - 24'h000001;
    end else begin
      memory_busy_pin_o <= 1'b0;
    end
  end

  // sticky fault flags; a new fault beats a clear in the same cycle
  logic [7:0] fault_reg;
  logic [7:0] fault_set;
  always_comb begin
    fault_set = 8'h00;
    fault_set[POS_PARITY_FAULT]   = is_write & parity_bad;
    fault_set[POS_MEMORY_FAULT]   = mem_cmd & memory_busy_pin_o;
    fault_set[POS_CHECKSUM_FAULT] = restore_go &
                                    (sum_of(nvm_mem_reg) != nvm_sum_reg);
  end
  wire logic clear_cmd = frame_ok & (cmd == CMD_CLEAR);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fault_reg <= RST_FAULT;
      fault_o   <= 1'b0;
    end else begin
      fault_reg <= (clear_cmd ? 8'h00 : fault_reg) | fault_set;
      fault_o   <= |((clear_cmd ? 8'h00 : fault_reg) | fault_set);
    end
  end

  // read reply goes out in the next frame
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reply_reg <= 16'h0000;
    end else if (frame_ok && cmd == CMD_READ) begin
      case (addr)
        ADDR_TRIM_AMOUNT: reply_reg <= {trim_amount_reg, 8'h00};
        ADDR_TRIM_AXES:   reply_reg <= {trim_axes_reg, 8'h00};
        ADDR_POWER_CFG:   reply_reg <= {power_cfg_reg, 8'h00};
        ADDR_FILTER:      reply_reg <= {filter_reg, 8'h00};
        ADDR_FAULT:       reply_reg <= {fault_reg, 8'h00};
        default:          reply_reg <= 16'h0000;
      endcase
    end else if (frame_ok) begin
      reply_reg <= 16'h0000;
    end
  end

  // power state
  aps_power_type state_reg;
  aps_power_type state_next;
  wire logic cycle_sel = power_cfg_reg[POS_CYCLE_REG_SEL];
  wire logic cycle_bit = power_cfg_reg[POS_AUTO_CYCLE];
  always_comb begin
    if (en_s)
      state_next = PWR_ON;
    else if (cycle_sel ? cycle_bit : asc_s)
      state_next = PWR_ASC;
    else
      state_next = PWR_IDLE;
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg     <= PWR_IDLE;
      power_state_o <= PWR_IDLE;
    end else begin
      state_reg     <= state_next;
      power_state_o <= state_next;
    end
  end

  // filter constant, latency and settling
  wire logic [3:0]  fw_code  = filter_reg[7:POS_FILTER_LSB];
  wire logic [12:0] tau      = tau_of(fw_code);
  wire logic [13:0] settle_us = {tau, 1'b0} - 14'h0001;
  logic [23:0] settle_cnt_reg;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      filter_tau_o <= 13'h0001;
      latency_us_o <= 14'h0000;
    end else begin
      filter_tau_o <= tau;
      latency_us_o <= {1'b0, tau} + 14'(LATENCY_EXTRA_US);
    end
  end

  // restarts on each entry to an active state; the window is sampled then.
  // keyed on the next state so that leaving idle loads the count and the
  // flag drops in the same cycle as power_state_o goes idle
  always_ff @(posedge clock_i) begin
    if (srst_i || state_next == PWR_IDLE) begin
      settle_cnt_reg <= 24'h000000;
      settled_flag_o <= 1'b0;
    end else if (state_reg != state_next) begin
      settle_cnt_reg <= 24'(settle_us * US_CYCLES);
      settled_flag_o <= 1'b0;
    end else if (settle_cnt_reg != 24'h000000) begin
      settle_cnt_reg <= settle_cnt_reg - 24'h000001;
    end else begin
      settled_flag_o <= 1'b1;
    end
  end

  // bias trim per axis
  wire logic tx_en = trim_axes_reg[POS_TRIM_X];
  wire logic ty_en = trim_axes_reg[POS_TRIM_Y];
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trim_x_amount_o   <= 8'h00;
      trim_y_amount_o   <= 8'h00;
      side_shaft_corr_o <= 1'b0;
    end else begin
      trim_x_amount_o   <= tx_en ? trim_amount_reg : 8'h00;
      trim_y_amount_o   <= ty_en ? trim_amount_reg : 8'h00;
      side_shaft_corr_o <= (tx_en ^ ty_en) &&
                           trim_amount_reg != 8'h00;
    end
  end

endmodule : aps_ctl

// file: verilog/aps_pkg.sv
/*
  Constants for the angle-sensor power, status and configuration logic:
  serial command codes, register indices, field positions, factory reset
  values and timing figures.
  Assumes a 20 MHz system clock and a 16-bit serial frame, optionally
  extended to 17 bits by a parity bit on register writes.
*/
package aps_pkg;
  // serial frame: cmd[15:13], address[12:8], data[7:0]
  localparam int          FRAME_BITS   = 16;
  localparam int          FRAME_PBITS  = 17;
  localparam logic [2:0]  CMD_READ     = 3'h2;
  localparam logic [2:0]  CMD_WRITE    = 3'h4;
  localparam logic [2:0]  CMD_RESTORE  = 3'h5;
  localparam logic [2:0]  CMD_STORE    = 3'h6;
  localparam logic [2:0]  CMD_CLEAR    = 3'h7;

  // register indices
  localparam logic [4:0]  ADDR_TRIM_AMOUNT = 5'h02;
  localparam logic [4:0]  ADDR_TRIM_AXES   = 5'h03;
  localparam logic [4:0]  ADDR_POWER_CFG   = 5'h0B;
  localparam logic [4:0]  ADDR_FILTER      = 5'h0E;
  localparam logic [4:0]  ADDR_FAULT       = 5'h1A;

  // field positions
  localparam int          POS_CYCLE_REG_SEL  = 7;
  localparam int          POS_AUTO_CYCLE     = 6;
  localparam int          POS_AUTO_ACTIVE    = 5;
  localparam int          POS_FILTER_LSB     = 4;
  localparam int          POS_TRIM_X         = 0;
  localparam int          POS_TRIM_Y         = 1;
  localparam int          POS_PARITY_FAULT   = 3;
  localparam int          POS_MEMORY_FAULT   = 2;
  localparam int          POS_CHECKSUM_FAULT = 1;

  // factory reset values
  localparam logic [7:0]  RST_TRIM_AMOUNT = 8'h00;
  localparam logic [7:0]  RST_TRIM_AXES   = 8'h00;
  localparam logic [7:0]  RST_POWER_CFG   = 8'hE0;
  localparam logic [7:0]  RST_FILTER      = 8'h90;
  localparam logic [7:0]  RST_FAULT       = 8'h00;

  // filter: time constant 2**code, saturating at code 12
  localparam logic [3:0]  FILTER_CODE_MAX = 4'hC;
  localparam int          LATENCY_EXTRA_US = 3;

  // timing
  localparam int          CLOCK_HZ        = 20_000_000;
  localparam int          CYCLES_PER_US   = CLOCK_HZ / 1_000_000;
  localparam int          NVM_BUSY_US     = 100;
  localparam int          NVM_BUSY_CYCLES = NVM_BUSY_US * CYCLES_PER_US;

  typedef enum logic [2:0] {
    PWR_IDLE = 3'b001,
    PWR_ASC  = 3'b010,
    PWR_ON   = 3'b100
  } aps_power_type;
endpackage : aps_pkg

// file: testbench/aps_ctl_checker.sv
/*
  Port-level checker for the sensor control block.
  Assumes it is bound into aps_ctl and shares its clock and reset.
*/
`timescale 1ns/100ps
module aps_ctl_checker
  import aps_pkg::*;
#(
  parameter int US_CYCLES   = 20,
  parameter int BUSY_CYCLES = 2000
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        cs_n_i,
  input  wire logic        fault_o,
  input  wire logic        memory_busy_pin_o,
  input  wire logic        settled_flag_o,
  input  wire logic [2:0]  power_state_o,
  input  wire logic [12:0] filter_tau_o,
  input  wire logic [13:0] latency_us_o,
  input  wire logic [7:0]  trim_x_amount_o,
  input  wire logic [7:0]  trim_y_amount_o,
  input  wire logic        side_shaft_corr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic [3:0] since_end_reg;
  // saturating, so a stale frame can never excuse a late flag change
  always_ff @(posedge clock_i) begin
    if (srst_i || !cs_n_i) since_end_reg <= 4'h0;
    else if (since_end_reg != 4'hF) since_end_reg <= since_end_reg + 4'h1;
  end
  sequence recent_end_s;
    cs_n_i && (since_end_reg < 4'h8);
  endsequence
  tau_onehot_a: assert property ($onehot(filter_tau_o))
    else $error("filter constant not a power of two");
  latency_sum_a: assert property (!$past(srst_i) |->
    latency_us_o == filter_tau_o + 14'h0003) else $error("latency wrong");
  power_onehot_a: assert property ($onehot(power_state_o))
    else $error("power state not one-hot");
  settled_idle_a: assert property ((power_state_o == PWR_IDLE)[*2]
    |-> !settled_flag_o) else $error("settled while idle");
  settled_rise_a: assert property ($rose(settled_flag_o) |->
    $stable(power_state_o) && power_state_o != PWR_IDLE)
    else $error("settled rose on a state change");
  trim_both_a: assert property (trim_x_amount_o != 8'h00 &&
    trim_y_amount_o != 8'h00 |-> trim_x_amount_o == trim_y_amount_o
    && !side_shaft_corr_o) else $error("both-axis trim wrong");
  side_corr_a: assert property (side_shaft_corr_o |->
    (trim_x_amount_o == 8'h00) != (trim_y_amount_o == 8'h00))
    else $error("correction without single axis");
  fault_sticky_a: assert property ($fell(fault_o) |-> recent_end_s)
    else $error("fault dropped without a frame");
  fault_cause_a: assert property ($rose(fault_o) |-> recent_end_s)
    else $error("fault rose without a frame");
  busy_start_a: assert property ($rose(memory_busy_pin_o) |->
    recent_end_s ##1 memory_busy_pin_o[*7]) else $error("busy pin wrong");
endmodule : aps_ctl_checker

bind aps_ctl aps_ctl_checker #(
  .US_CYCLES(US_CYCLES), .BUSY_CYCLES(BUSY_CYCLES)
) chk_u (
  .clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .fault_o(fault_o),
  .memory_busy_pin_o(memory_busy_pin_o), .settled_flag_o(settled_flag_o),
  .power_state_o(power_state_o), .filter_tau_o(filter_tau_o),
  .latency_us_o(latency_us_o), .trim_x_amount_o(trim_x_amount_o),
  .trim_y_amount_o(trim_y_amount_o), .side_shaft_corr_o(side_shaft_corr_o)
);

// file: testbench/aps_host_model.sv
/*
  Serial host model that sends frames to the sensor.
  Assumes mode 0 and a half period of five system clocks.
*/
`timescale 1ns/100ps
module aps_host_model (
  input  wire logic clock_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      cs_n_o
);
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b1;
    cs_n_o = 1'b1;
  end
  task automatic tick;
    repeat (5) @(posedge clock_i);
  endtask : tick
  task automatic frame(input logic [15:0] word, input logic with_par,
                       input logic par, output logic [15:0] rx);
    logic [16:0] bits;
    int          n;
    bits = {word, par};
    n = with_par ? 17 : 16;
    rx = 16'h0000;
    cs_n_o <= 1'b0;
    tick();
    for (int i = 16; i > 16 - n; i--) begin
      mosi_o <= bits[i];
      tick();
      sclk_o <= 1'b1;
      tick();
      if (i > 0) rx = {rx[14:0], miso_i};
      sclk_o <= 1'b0;
    end
    tick();
    cs_n_o <= 1'b1;
    // released line must not keep showing the last bit
    mosi_o <= ~mosi_o;
    repeat (12) @(posedge clock_i);
  endtask : frame
endmodule : aps_host_model

// file: testbench/aps_ctl_tb_top.sv
/*
  Self-checking bench for the sensor control block.
  Assumes shortened timing parameters and the serial host model.
*/
`timescale 1ns/100ps
module aps_ctl_tb_top;
  import aps_pkg::*;
  logic        clock_i, srst_i, parity_mode_i, enable_pin_i, cyc_pin;
  logic        sclk, mosi, cs_n, miso, fault, busy, settled, corr;
  logic [2:0]  pwr;
  logic [12:0] tau;
  logic [13:0] lat;
  logic [7:0]  tx, ty, rv;
  logic [15:0] rx;
  int          num_errors = 0;
  int          checked = 0;
  logic [3:0]  codes [5] = '{4'h0, 4'hC, 4'hF, 4'h5, 4'h2};
  logic [7:0]  p_reg [5] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'hC0};
  logic [1:0]  p_pin [5] = '{2'b01, 2'b10, 2'b01, 2'b00, 2'b00};
  logic [2:0]  p_exp [5] = '{PWR_IDLE, PWR_ON, PWR_ASC, PWR_IDLE, PWR_ASC};
  aps_ctl #(.US_CYCLES(1), .BUSY_CYCLES(400)) dut_u (
    .clock_i(clock_i), .srst_i(srst_i), .sclk_i(sclk), .mosi_i(mosi),
    .cs_n_i(cs_n), .parity_mode_i(parity_mode_i),
    .enable_pin_i(enable_pin_i), .auto_cycle_pin_i(cyc_pin),
    .miso_o(miso), .fault_o(fault), .memory_busy_pin_o(busy),
    .settled_flag_o(settled), .power_state_o(pwr), .filter_tau_o(tau),
    .latency_us_o(lat), .trim_x_amount_o(tx), .trim_y_amount_o(ty),
    .side_shaft_corr_o(corr));
  aps_host_model host_u (.clock_i(clock_i), .miso_i(miso), .sclk_o(sclk),
    .mosi_o(mosi), .cs_n_o(cs_n));
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic send(input logic [2:0] cmd, input logic [4:0] addr,
                      input logic [7:0] data, input logic bad = 1'b0);
    logic [15:0] w;
    w = {cmd, addr, data};
    host_u.frame(w, parity_mode_i && cmd == CMD_WRITE, (^w) ^ bad, rx);
  endtask : send
  task automatic rd(input logic [4:0] addr);
    send(CMD_READ, addr, 8'h00);
    send(3'h0, 5'h00, 8'h00);
    rv = rx[15:8];
  endtask : rd
  task automatic wait_idle;
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clock_i);
  endtask : wait_idle
  task automatic wrap_up;
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    wrap_up();
  end
  initial begin
    srst_i <= 1'b1;
    parity_mode_i <= 1'b0;
    enable_pin_i <= 1'b0;
    cyc_pin <= 1'b0;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    chk("tau", 16'h0200, tau);
    chk("lat", 16'h0203, lat);
    chk("pwr", PWR_ASC, pwr);
    chk("settled", 16'h0000, settled);
    foreach (codes[i]) begin
      send(CMD_WRITE, ADDR_FILTER, {codes[i], 4'h0});
      chk("tau", 16'h0001 << (codes[i] > 4'hC ? 4'hC : codes[i]), tau);
      chk("lat", (16'h0001 << (codes[i] > 4'hC ? 4'hC : codes[i])) + 16'h0003,
          lat);
    end
    for (int i = 0; i < 5; i++) begin
      {enable_pin_i, cyc_pin} <= p_pin[i];
      send(CMD_WRITE, ADDR_POWER_CFG, p_reg[i]);
      chk("pwr", p_exp[i], pwr);
    end
    repeat (20) @(posedge clock_i);
    chk("settled", 16'h0001, settled);
    enable_pin_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk("settled", 16'h0000, settled);
    repeat (20) @(posedge clock_i);
    chk("settled", 16'h0001, settled);
    enable_pin_i <= 1'b0;
    send(CMD_WRITE, ADDR_POWER_CFG, 8'h80);
    chk("settled", 16'h0000, settled);
    send(CMD_WRITE, ADDR_TRIM_AMOUNT, 8'h56);
    send(CMD_WRITE, ADDR_TRIM_AXES, 8'h01);
    chk("tx", 16'h0056, tx);
    chk("ty", 16'h0000, ty);
    chk("corr", 16'h0001, corr);
    send(CMD_WRITE, ADDR_TRIM_AXES, 8'h03);
    chk("ty", 16'h0056, ty);
    chk("corr", 16'h0000, corr);
    parity_mode_i <= 1'b1;
    @(posedge clock_i);
    send(CMD_WRITE, ADDR_FILTER, 8'h30, 1'b1);
    chk("tau", 16'h0004, tau);
    chk("fault", 16'h0001, fault);
    send(CMD_WRITE, ADDR_TRIM_AMOUNT, 8'h11);
    chk("tx", 16'h0011, tx);
    send(CMD_WRITE, ADDR_FAULT, 8'hFF);
    rd(ADDR_FAULT);
    chk("status", 16'h0008, rv);
    send(CMD_CLEAR, 5'h00, 8'h00);
    chk("fault", 16'h0000, fault);
    parity_mode_i <= 1'b0;
    @(posedge clock_i);
    send(CMD_STORE, 5'h00, 8'h00);
    chk("busy", 16'h0001, busy);
    send(CMD_STORE, 5'h00, 8'h00);
    rd(ADDR_FAULT);
    chk("status", 16'h0004, rv);
    chk("fault", 16'h0001, fault);
    send(CMD_CLEAR, 5'h00, 8'h00);
    wait_idle();
    send(CMD_WRITE, ADDR_FILTER, 8'h70);
    send(CMD_RESTORE, 5'h00, 8'h00);
    wait_idle();
    chk("tau", 16'h0004, tau);
    chk("fault", 16'h0000, fault);
    wrap_up();
  end
endmodule : aps_ctl_tb_top
